// ---- inc/aso_pkg.sv ----
// package: constants and types for the adc sample output interface
package aso_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int SAMPLE_W = 16;
    localparam int PAIRS = 8;
    localparam int CLK_MHZ = 50;
    // ************************************************************
    // wake-up times after output enable, in ns and in cycles
    // ************************************************************
    localparam int WAKE_DDR_NS = 700;
    localparam int WAKE_PAR_NS = 200;
    localparam int WAKE_DDR_CYC = (WAKE_DDR_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_PAR_CYC = (WAKE_PAR_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_W = 6;
    // ************************************************************
    // codes and reset values
    // ************************************************************
    localparam logic [15:0] OB_POS_FULL = 16'hffff;
    localparam logic [15:0] OB_NEG_FULL = 16'h0000;
    localparam logic [1:0] CURR_RST = 2'h0;   // 00 selects 3.5 mA
    localparam logic [1:0] CURR_2P5 = 2'h1;
    localparam logic [1:0] CURR_4P5 = 2'h2;
    localparam logic [1:0] CURR_1P95 = 2'h3;
    localparam logic [2:0] TERM_RST = 3'h0;   // open
    localparam logic [2:0] POSN_RST = 3'h0;   // default clock position
    // ************************************************************
    // launch phase states
    // ************************************************************
    typedef enum logic [1:0] {
        PH_LOW = 2'b01,
        PH_HIGH = 2'b10
    } aso_phase_type;
endpackage

// ---- src/aso_sync.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module aso_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else if (ce_i)
        begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule // aso_sync

// ---- src/aso_output.sv ----
// sample formatting, saturation and ddr / parallel output driver
//
// How it works
// - 16-bit data, aligned clock, out-of-range flag
// - output disable tristates all data and clock
// - mode from strap or serial select bit
// - ddr: two bits per pair, eight pairs
// - even bits on falling, odd on rising
// - drive current default 3.5 mA, programmable
// - current double, separate data and clock
// - three terminations, separate data and clock
// - parallel: bit per pin, valid rising
// - clock position from strap or field
// - format from strap or serial bit
// - positive overdrive saturates ffff / 7fff
// - negative overdrive saturates 0000 / 8000
// - valid data 700/200 ns after enable
`timescale 1ns/100ps
module aso_output #(
    parameter int SAMPLE_W = aso_pkg::SAMPLE_W,
    parameter int PAIRS = aso_pkg::PAIRS
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic sample_clk_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic over_pos_i,
    input wire logic over_neg_i,
    input wire logic output_enable_i,
    input wire logic format_select_strap_i,
    input wire logic position_strap_pin_i,
    input wire logic serial_override_i,
    input wire logic interface_select_bit_i,
    input wire logic twos_comp_bit_i,
    input wire logic [2:0] clock_position_field_i,
    input wire logic [1:0] data_current_i,
    input wire logic [1:0] clock_current_i,
    input wire logic data_current_double_i,
    input wire logic clock_current_double_i,
    input wire logic [2:0] data_term_i,
    input wire logic [2:0] clock_termination_setting_i,
    output logic [PAIRS-1:0] ddr_data_o,
    output logic [PAIRS-1:0] ddr_data_oe_n_o,
    output logic forwarded_clock_positive_o,
    output logic forwarded_clock_oe_n_o,
    output logic [SAMPLE_W-1:0] par_data_o,
    output logic [SAMPLE_W-1:0] par_data_oe_n_o,
    output logic parallel_output_clock_o,
    output logic parallel_output_clock_oe_n_o,
    output logic out_of_range_o,
    output logic data_valid_o,
    output logic ddr_mode_o,
    output logic [1:0] data_drive_current_setting_o,
    output logic [1:0] clock_drive_current_setting_o,
    output logic data_current_double_bit_o,
    output logic clock_current_double_bit_o,
    output logic [2:0] data_term_o,
    output logic [2:0] clock_term_o,
    output logic [2:0] clock_posn_o
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [SAMPLE_W+5:0] sync_q;
    logic sclk_s;
    logic ovp_s;
    logic ovn_s;
    logic oe_s;
    logic strap_s;
    logic posn_s;
    logic [SAMPLE_W-1:0] smp_s;

    aso_sync #(.W(SAMPLE_W + 6)) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .d_i({sample_clk_i, over_pos_i, over_neg_i, output_enable_i,
              format_select_strap_i, position_strap_pin_i, sample_i}),
        .q_o(sync_q)
    );
    assign {sclk_s, ovp_s, ovn_s, oe_s, strap_s, posn_s, smp_s} = sync_q;

    // ************************************************************
    // sample clock edge detect and mode selection
    // ************************************************************
    logic sclk_d_ff;
    logic rise;
    logic fall;
    logic ddr_sel;
    logic twos_sel;
    logic [2:0] posn_sel;

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            sclk_d_ff <= 1'b0;
        else if (ce_i)
            sclk_d_ff <= sclk_s;
    end
    assign rise = sclk_s & ~sclk_d_ff;
    assign fall = ~sclk_s & sclk_d_ff;
    assign ddr_sel = serial_override_i ? interface_select_bit_i : strap_s;
    assign twos_sel = serial_override_i ? twos_comp_bit_i : strap_s;
    assign posn_sel = serial_override_i ? clock_position_field_i
                                        : {2'h0, posn_s};

    // ************************************************************
    // formatting and saturation
    // ************************************************************
    logic [SAMPLE_W-1:0] ob_code;
    logic [SAMPLE_W-1:0] fmt_code;
    logic [SAMPLE_W-1:0] word_ff;
    logic oor_ff;

    always_comb
    begin
        if (ovp_s)
            ob_code = aso_pkg::OB_POS_FULL;
        else if (ovn_s)
            ob_code = aso_pkg::OB_NEG_FULL;
        else
            ob_code = smp_s;
        fmt_code = ob_code ^ {twos_sel, {(SAMPLE_W-1){1'b0}}};
    end

    // capture one formatted word per sample clock rise
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            word_ff <= '0;
            oor_ff <= 1'b0;
        end
        else if (ce_i && rise)
        begin
            word_ff <= fmt_code;
            oor_ff <= (ob_code == aso_pkg::OB_POS_FULL) ||
                      (ob_code == aso_pkg::OB_NEG_FULL);
        end
    end

    // ************************************************************
    // wake-up counter after output enable
    // ************************************************************
    logic [aso_pkg::WAKE_W-1:0] wake_ff;
    logic [aso_pkg::WAKE_W-1:0] wake_target;

    assign wake_target = ddr_sel ? aso_pkg::WAKE_W'(aso_pkg::WAKE_DDR_CYC)
                                 : aso_pkg::WAKE_W'(aso_pkg::WAKE_PAR_CYC);
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            wake_ff <= '0;
        else if (ce_i)
        begin
            if (!oe_s)
                wake_ff <= '0;
            else if (wake_ff < wake_target)
                wake_ff <= wake_ff + 1'b1;
        end
    end

    // ************************************************************
    // launch phase and pin drivers
    // ************************************************************
    aso_pkg::aso_phase_type phase_ff;
    logic [SAMPLE_W-1:0] launch_ff;
    logic [PAIRS-1:0] ddr_ff;
    logic fclk_ff;
    logic oor_launch_ff;

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            phase_ff <= aso_pkg::PH_LOW;
        else if (ce_i)
        begin
            unique case (phase_ff)
                aso_pkg::PH_LOW: if (rise) phase_ff <= aso_pkg::PH_HIGH;
                aso_pkg::PH_HIGH: if (fall) phase_ff <= aso_pkg::PH_LOW;
            endcase
        end
    end

    // eight pairs carry two bits each
    genvar gi;
    generate
        for (gi = 0; gi < PAIRS; gi++)
        begin : g_pair
            always_ff @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    ddr_ff[gi] <= 1'b0;
                else if (ce_i && fall && phase_ff == aso_pkg::PH_HIGH)
                    ddr_ff[gi] <= word_ff[2*gi];
                else if (ce_i && rise && phase_ff == aso_pkg::PH_LOW)
                    ddr_ff[gi] <= launch_ff[2*gi+1];
            end
        end
    endgenerate

    // parallel word launched at fall, valid at rise
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            launch_ff <= '0;
            fclk_ff <= 1'b0;
            oor_launch_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (fall)
            begin
                launch_ff <= word_ff;
                oor_launch_ff <= oor_ff;
            end
            // position 0 aligned, else inverted clock
            fclk_ff <= (posn_sel == aso_pkg::POSN_RST) ? sclk_s : ~sclk_s;
        end
    end

    // outputs and enables
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ddr_data_oe_n_o <= '1;
            forwarded_clock_oe_n_o <= 1'b1;
            par_data_oe_n_o <= '1;
            parallel_output_clock_oe_n_o <= 1'b1;
            data_valid_o <= 1'b0;
            ddr_mode_o <= 1'b0;
            out_of_range_o <= 1'b0;
            par_data_o <= '0;
            ddr_data_o <= '0;
            forwarded_clock_positive_o <= 1'b0;
            parallel_output_clock_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ddr_data_oe_n_o <= {PAIRS{~(oe_s & ddr_sel)}};
            forwarded_clock_oe_n_o <= ~(oe_s & ddr_sel);
            par_data_oe_n_o <= {SAMPLE_W{~(oe_s & ~ddr_sel)}};
            parallel_output_clock_oe_n_o <= ~(oe_s & ~ddr_sel);
            data_valid_o <= oe_s && (wake_ff >= wake_target);
            ddr_mode_o <= ddr_sel;
            out_of_range_o <= oor_launch_ff;
            par_data_o <= launch_ff;
            ddr_data_o <= ddr_ff;
            forwarded_clock_positive_o <= fclk_ff;
            parallel_output_clock_o <= fclk_ff;
        end
    end

    // ************************************************************
    // analog drive settings: reset defaults, then registered from the inputs
    // ************************************************************
    // drive and termination registers
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            data_drive_current_setting_o <= aso_pkg::CURR_RST;
            clock_drive_current_setting_o <= aso_pkg::CURR_RST;
            data_current_double_bit_o <= 1'b0;
            clock_current_double_bit_o <= 1'b0;
            data_term_o <= aso_pkg::TERM_RST;
            clock_term_o <= aso_pkg::TERM_RST;
            clock_posn_o <= aso_pkg::POSN_RST;
        end
        else if (ce_i)
        begin
            data_drive_current_setting_o <= data_current_i;
            clock_drive_current_setting_o <= clock_current_i;
            data_current_double_bit_o <= data_current_double_i;
            clock_current_double_bit_o <= clock_current_double_i;
            data_term_o <= data_term_i;
            clock_term_o <= clock_termination_setting_i;
            clock_posn_o <= posn_sel;
        end
    end
endmodule // aso_output

// ---- test/aso_chk.sv ----
// checker: port-level assertions for the sample output block
`timescale 1ns/100ps
module aso_chk #(
    parameter int SAMPLE_W = 16,
    parameter int PAIRS = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic output_enable_i,
    input wire logic format_select_strap_i,
    input wire logic position_strap_pin_i,
    input wire logic serial_override_i,
    input wire logic interface_select_bit_i,
    input wire logic [PAIRS-1:0] ddr_data_oe_n_o,
    input wire logic forwarded_clock_oe_n_o,
    input wire logic [SAMPLE_W-1:0] par_data_o,
    input wire logic [SAMPLE_W-1:0] par_data_oe_n_o,
    input wire logic parallel_output_clock_o,
    input wire logic parallel_output_clock_oe_n_o,
    input wire logic out_of_range_o,
    input wire logic data_valid_o,
    input wire logic ddr_mode_o,
    input wire logic [2:0] clock_posn_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    // ********
    // helper: cycles of steady enable in one mode
    // ********
    logic [5:0] on_cnt;
    logic mode_q;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            on_cnt <= 6'h00;
            mode_q <= 1'b0;
        end
        else
        begin
            mode_q <= ddr_mode_o;
            if (!output_enable_i || ddr_mode_o != mode_q)
                on_cnt <= 6'h00;
            else if (on_cnt != 6'h3f)
                on_cnt <= on_cnt + 6'h01;
        end
    end
    // ********
    // properties
    // ********
    sequence s_off;
        !output_enable_i [*4];
    endsequence
    sequence s_on;
        // fifty steady cycles: 49 counted plus this one
        (on_cnt >= 6'h31) && output_enable_i && $stable(ddr_mode_o);
    endsequence
    property p_oe_off;
        s_off |-> &ddr_data_oe_n_o && forwarded_clock_oe_n_o
            && &par_data_oe_n_o && parallel_output_clock_oe_n_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("outputs driven while disabled");
    property p_valid_off;
        s_off |-> !data_valid_o;
    endproperty
    a_valid_off: assert property (p_valid_off)
        else $error("valid while disabled");
    property p_wake_min;
        $rose(output_enable_i) |-> !data_valid_o [*8];
    endproperty
    a_wake_min: assert property (p_wake_min)
        else $error("valid too soon after enable");
    property p_wake_max;
        s_on |-> data_valid_o;
    endproperty
    a_wake_max: assert property (p_wake_max)
        else $error("valid too late after enable");
    property p_sat;
        out_of_range_o && data_valid_o && !ddr_mode_o |->
            par_data_o inside {16'hffff, 16'h7fff, 16'h0000, 16'h8000};
    endproperty
    a_sat: assert property (p_sat)
        else $error("range flag without full-scale code");
    property p_clk_drv;
        data_valid_o |-> (ddr_mode_o ? !forwarded_clock_oe_n_o
            : !parallel_output_clock_oe_n_o);
    endproperty
    a_clk_drv: assert property (p_clk_drv)
        else $error("valid data without output clock");
    property p_par_stable;
        $rose(parallel_output_clock_o) && data_valid_o && !ddr_mode_o
            && clock_posn_o == 3'h0 && !position_strap_pin_i
            |-> $stable(par_data_o);
    endproperty
    a_par_stable: assert property (p_par_stable)
        else $error("parallel data moved at clock rise");
    property p_mode;
        $stable({serial_override_i, interface_select_bit_i,
            format_select_strap_i}) [*6] |-> ddr_mode_o == (serial_override_i
            ? interface_select_bit_i : format_select_strap_i);
    endproperty
    a_mode: assert property (p_mode)
        else $error("interface mode wrong");
endmodule // aso_chk

bind aso_output aso_chk #(.SAMPLE_W(SAMPLE_W), .PAIRS(PAIRS)) u_chk (.*);

// ---- test/aso_rx.sv ----
// partner: receiver taking ddr pairs on both forwarded clock edges
`timescale 1ns/100ps
module aso_rx (
    input wire logic mclk_i,
    input wire logic fwd_clk_i,
    input wire logic [7:0] pair_i,
    input wire logic [7:0] pair_oe_n_i,
    output logic [15:0] word_o
);
    logic clk_ff;
    logic [7:0] pair_ff;
    logic [7:0] even_ff;
    always_ff @(posedge mclk_i)
    begin
        clk_ff <= fwd_clk_i;
        // released pairs float: show the inverse, never a stale value
        pair_ff <= (pair_oe_n_i == 8'h00) ? pair_i : ~pair_ff;
        if (fwd_clk_i && !clk_ff)
            even_ff <= pair_ff;
        if (!fwd_clk_i && clk_ff)
            for (int k = 0; k < 8; k++)
            begin
                word_o[2*k] <= even_ff[k];
                word_o[2*k+1] <= pair_ff[k];
            end
    end
endmodule // aso_rx

// ---- test/testbench.sv ----
// testbench: scenarios for the sample output block
`timescale 1ns/100ps
module testbench;
    logic mclk_i, reset_n_i, sclk, over_pos, over_neg, oe, strap, ovr;
    logic isel, twos, ddbl, cdbl, fclk, fclk_oe_n, pclk, pclk_oe_n, pstrap;
    logic oor, valid, ddr_mode, ddbl_o, cdbl_o;
    logic [15:0] sample, par_d, par_oe_n, rx_word;
    logic [2:0] posn, dterm, cterm, dterm_o, cterm_o, posn_o;
    logic [1:0] dcur, ccur, dcur_o, ccur_o;
    logic [7:0] ddr_d, ddr_oe_n;
    int mismatches, comparisons;
    // ********
    // design and receiver
    // ********
    aso_output DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
        .sample_clk_i(sclk), .sample_i(sample), .over_pos_i(over_pos),
        .over_neg_i(over_neg), .output_enable_i(oe),
        .format_select_strap_i(strap), .position_strap_pin_i(pstrap),
        .serial_override_i(ovr), .interface_select_bit_i(isel),
        .twos_comp_bit_i(twos), .clock_position_field_i(posn),
        .data_current_i(dcur), .clock_current_i(ccur),
        .data_current_double_i(ddbl), .clock_current_double_i(cdbl),
        .data_term_i(dterm), .clock_termination_setting_i(cterm),
        .ddr_data_o(ddr_d), .ddr_data_oe_n_o(ddr_oe_n),
        .forwarded_clock_positive_o(fclk), .forwarded_clock_oe_n_o(fclk_oe_n),
        .par_data_o(par_d), .par_data_oe_n_o(par_oe_n),
        .parallel_output_clock_o(pclk),
        .parallel_output_clock_oe_n_o(pclk_oe_n), .out_of_range_o(oor),
        .data_valid_o(valid), .ddr_mode_o(ddr_mode),
        .data_drive_current_setting_o(dcur_o),
        .clock_drive_current_setting_o(ccur_o),
        .data_current_double_bit_o(ddbl_o), .clock_current_double_bit_o(cdbl_o),
        .data_term_o(dterm_o), .clock_term_o(cterm_o),
        .clock_posn_o(posn_o));
    aso_rx rx (.mclk_i(mclk_i), .fwd_clk_i(fclk), .pair_i(ddr_d),
        .pair_oe_n_i(ddr_oe_n), .word_o(rx_word));
    // system clock and free-running sampling clock
    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial
    begin
        sclk = 1'b0;
        #7;
        forever #80 sclk = ~sclk;
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // settings echo over a walk of codes
    task automatic t_settings();
        // ddr mode while the clock position walks
        ovr <= 1'b1;
        isel <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            dcur <= i[1:0];
            ccur <= ~i[1:0];
            ddbl <= i[0];
            cdbl <= ~i[0];
            dterm <= i[2:0];
            cterm <= ~i[2:0];
            posn <= i[2:0];
            step(6);
            chk("settings", {4'h0, i[1:0], ~i[1:0], i[0], ~i[0], i[2:0],
                ~i[2:0]}, {4'h0, dcur_o, ccur_o, ddbl_o, cdbl_o, dterm_o,
                cterm_o});
            chk("posn", {13'h0, i[2:0]}, {13'h0, posn_o});
        end
        // strap picks ddr mode and the shifted clock position
        posn <= 3'h0;
        ovr <= 1'b0;
        strap <= 1'b1;
        pstrap <= 1'b1;
        step(6);
        chk("posn strap", 16'h0001, {13'h0, posn_o});
        pstrap <= 1'b0;
        step(6);
    endtask
    // one mode / format / overdrive case, ddr word judged at the receiver, the rest at the pins
    task automatic t_case(input logic o_s, i_s, t_s, s_s, input int o);
        logic dd;
        logic [15:0] e;
        dd = o_s ? i_s : s_s;
        e = (o == 1) ? 16'hffff : (o == 2) ? 16'h0000 : 16'h1234;
        e[15] = e[15] ^ (o_s ? t_s : s_s);
        ovr <= o_s;
        isel <= i_s;
        twos <= t_s;
        strap <= s_s;
        over_pos <= (o == 1);
        over_neg <= (o == 2);
        step(40);
        chk("mode", {15'h0, dd}, {15'h0, ddr_mode});
        chk("word", e, dd ? rx_word : par_d);
        chk("range", {15'h0, o != 0}, {15'h0, oor});
    endtask
    // disable, then time the wake-up in each mode
    task automatic t_oe(input logic m);
        int n;
        int w;
        w = m ? aso_pkg::WAKE_DDR_CYC : aso_pkg::WAKE_PAR_CYC;
        n = 0;
        ovr <= 1'b1;
        isel <= m;
        step(40);
        oe <= 1'b0;
        step(6);
        chk("released", 16'h001e, {11'h0, &ddr_oe_n, fclk_oe_n, &par_oe_n,
            pclk_oe_n, valid});
        oe <= 1'b1;
        while (valid !== 1'b1 && n < 100)
        begin
            step(1);
            n++;
        end
        chk("wake", 16'h1, {15'h0, n >= w && n <= w + 6});
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {reset_n_i, over_pos, over_neg, strap, ovr, isel, twos, pstrap} = 8'h0;
        {ddbl, cdbl, posn, dterm, cterm, dcur, ccur} = 15'h0;
        oe = 1'b1;
        sample = 16'h1234;
        step(2);
        reset_n_i <= 1'b1;
        step(4);
        chk("reset", 16'h0, {1'b0, dcur_o, ccur_o, ddbl_o, cdbl_o, dterm_o,
            cterm_o, posn_o});
        t_settings();
        for (int o = 0; o < 3; o++)
        begin
            t_case(1'b1, 1'b0, 1'b0, 1'b0, o);
            t_case(1'b1, 1'b0, 1'b1, 1'b0, o);
            t_case(1'b0, 1'b1, 1'b1, 1'b0, o);
            t_case(1'b0, 1'b0, 1'b0, 1'b1, o);
            t_case(1'b1, 1'b1, 1'b0, 1'b0, o);
        end
        t_oe(1'b0);
        t_oe(1'b1);
        end_of_test();
    end
endmodule // testbench
